/* File: verilog/lcdc_defines.svh */
/*
  Constants for the dot-matrix display command decoder: command codes,
  field positions, reset values and timing counts.
  Assumes a 125 MHz core clock.
*/
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH
`define LCDC_CLK_MHZ        125
`define LCDC_RST_TIME_NS    1000
`define LCDC_RST_CYC        ((`LCDC_RST_TIME_NS * `LCDC_CLK_MHZ) / 1000)
`define LCDC_CMD_DISP       8'hae
`define LCDC_CMD_SEG        8'ha0
`define LCDC_CMD_ALLON      8'ha4
`define LCDC_CMD_INV        8'ha6
`define LCDC_CMD_BIAS       8'ha2
`define LCDC_CMD_RMW        8'he0
`define LCDC_CMD_END        8'hee
`define LCDC_CMD_SWRST      8'he2
`define LCDC_CMD_NOP        8'he3
`define LCDC_CMD_VOL        8'h81
`define LCDC_CMD_IND        8'hac
`define LCDC_CMD_BOOST      8'hf8
`define LCDC_NIB_PAGE       4'hb
`define LCDC_NIB_COLHI      4'h1
`define LCDC_NIB_COLLO      4'h0
`define LCDC_NIB_COM        4'hc
`define LCDC_NIB_TEST       4'hf
`define LCDC_TOP2_START     2'h1
`define LCDC_TOP5_PWR       5'h05
`define LCDC_TOP5_RATIO     5'h04
`define LCDC_COM_BIT        3
`define LCDC_VOL_RST        6'h20
`define LCDC_RATIO_RST      3'h0
`define LCDC_FIFO_DEPTH     8
`endif

/* File: verilog/lcdc_pkg.sv */
/*
  Types for the display command decoder.
  Assumes lcdc_defines.svh is available on the include path.
*/
package lcdc_pkg;
  typedef logic [7:0] lcdc_byte_t;
  typedef enum logic [1:0] {LCDC_ST_CMD, LCDC_ST_VOL, LCDC_ST_IND, LCDC_ST_BOOST} lcdc_state_t;
endpackage

/* File: verilog/lcdc_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module lcdc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce_in) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        mem_r[wp_r] <= in_data_in;
      end
    end
  end
endmodule // lcdc_fifo

/* File: verilog/lcdc_decoder.sv */
/*
  Command and display-data decoder of a 128x64 dot-matrix display controller.
  Bus pins are taken synchronous to clock_in; the data bus is split into
  input, output and output enable. The hardware reset pin is low active.
*/
`timescale 1ns/1ps
`include "lcdc_defines.svh"

// How it works
// R1 - Display on/off blanks or shows panel
// R2 - 01xxxxxx loads display start line
// R3 - 1011xxxx loads page pointer
// R4 - Column pointer set in two nibbles
// R5 - Status read gives flags high, zeros low
// R6 - Data write stores at page/column
// R7 - Data read returns RAM, parallel only
// R8 - Segment order normal or reversed
// R9 - Inversion shows every bit inverted
// R10 - All-points forces every dot on
// R11 - Bias select 1/9 or 1/7
// R12 - Read-modify-write: write advances, read holds
// R13 - Common scan direction from bit 3
// R14 - 00101xxx loads supply operating mode
// R15 - 00100xxx loads regulator resistor ratio
// R16 - Contrast is a two-byte sequence
// R17 - Indicator on/off plus flashing mode byte
// R18 - Booster ratio second byte selects boost
// R19 - Display off with all-on is power saver
// R20 - Host never sends upper nibble 1111; the bench sends 0xf8 as the booster lead
// R21 - Reset pulse 1 us, done within 1 us
// R22 - Host follows recommended init order
// R23 - Data/command select: high data, low command
// R24 - 8080 write latched on write strobe rise
// R25 - 6800 read/write high read, enable high
// R26 - Serial: data on bit 7, clock bit 6
// R27 - Data access advances column pointer
// R28 - Software reset restores pointers and settings; code keeps bias, power mode, ratio, contrast, indicator, booster
// R29 - No-operation changes nothing
module lcdc_decoder (
  input  wire logic          clock_in,
  input  wire logic          srst_in,
  input  wire logic          ce_in,
  input  wire logic          hw_reset_n_in,
  input  wire logic          parallel_sel_in,
  input  wire logic          bus_style_select_in,
  input  wire logic          unit_select_n_in,
  input  wire logic          data_cmd_in,
  input  wire logic          rd_e_in,
  input  wire logic          wr_rw_in,
  input  wire logic [7:0]    bus_data_in,
  output lcdc_pkg::lcdc_byte_t bus_data_out,
  output logic               bus_data_oe_out,
  output logic               display_on_out,
  output logic [5:0]         start_line_out,
  output logic [3:0]         page_out,
  output logic [7:0]         column_out,
  output logic               seg_reverse_out,
  output logic               com_reverse_out,
  output logic               invert_out,
  output logic               all_on_out,
  output logic               bias_1_7_out,
  output logic [2:0]         power_mode_out,
  output logic [2:0]         reg_ratio_out,
  output logic [5:0]         contrast_out,
  output logic               indicator_on_out,
  output logic [1:0]         indicator_mode_out,
  output logic [1:0]         booster_out,
  output logic               power_saver_out,
  output logic               rmw_out,
  output logic               busy_out
);
  import lcdc_pkg::*;

  localparam int RST_CYC = (`LCDC_RST_CYC < 1) ? 1 : `LCDC_RST_CYC;
  localparam int RCW     = $clog2(RST_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus sampling: strobe edges become one-cycle access events.

  logic       rd_q_r, wr_q_r, sck_q_r, rd_nxt, wr_nxt, sck_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] bc_r, bc_nxt;
  logic       acc_v, acc_wr, acc_dc;
  logic [7:0] acc_d;
  logic       sel, rd_act, wr_act;

  assign sel = !unit_select_n_in && parallel_sel_in;
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (bus_style_select_in) begin
      rd_act = rd_e_in && wr_rw_in; // R25
      wr_act = rd_e_in && !wr_rw_in; // R25
    end else begin
      rd_act = !rd_e_in;
      wr_act = !wr_rw_in;
    end
  end

  always_comb begin
    rd_nxt  = sel && rd_act;
    wr_nxt  = sel && wr_act;
    sck_nxt = bus_data_in[6];
    sh_nxt  = sh_r;
    bc_nxt  = bc_r;
    acc_v   = 1'b0;
    acc_wr  = 1'b1;
    acc_dc  = data_cmd_in; // R23
    acc_d   = bus_data_in;
    if (parallel_sel_in) begin
      bc_nxt = '0;
      if (wr_q_r && !wr_nxt) begin
        acc_v = 1'b1; // R24
      end else if (rd_nxt && !rd_q_r) begin
        acc_v  = 1'b1; // R7
        acc_wr = 1'b0;
      end
    end else if (unit_select_n_in) begin
      bc_nxt = '0;
    end else if (bus_data_in[6] && !sck_q_r) begin
      sh_nxt = {sh_r[6:0], bus_data_in[7]}; // R26
      bc_nxt = bc_r + 3'h1;
      if (bc_r == 3'h7) begin
        acc_v = 1'b1; // R26
        acc_d = {sh_r[6:0], bus_data_in[7]};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_q_r  <= 1'b0;
      wr_q_r  <= 1'b0;
      sck_q_r <= 1'b0;
      sh_r    <= '0;
      bc_r    <= '0;
    end else if (ce_in) begin
      rd_q_r  <= rd_nxt;
      wr_q_r  <= wr_nxt;
      sck_q_r <= sck_nxt;
      sh_r    <= sh_nxt;
      bc_r    <= bc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path through the FIFO; it stalls while reset is in progress, so
  // bytes arriving then are held rather than lost, up to its depth.

  logic       f_ready, f_valid, f_pop, f_dc;
  logic [7:0] f_d;
  logic [RCW-1:0] rc_r, rc_nxt;

  lcdc_fifo #(.WIDTH(9), .DEPTH(`LCDC_FIFO_DEPTH)) u_fifo (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .ce_in         (ce_in),
    .in_data_in    ({acc_dc, acc_d}),
    .in_valid_in   (acc_v && acc_wr),
    .in_ready_out  (f_ready),
    .out_data_out  ({f_dc, f_d}),
    .out_valid_out (f_valid),
    .out_ready_in  (rc_r == '0)
  );
  assign f_pop    = f_valid && (rc_r == '0);
  assign busy_out = (rc_r != '0) || !f_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter and display settings.

  logic [7:0] ram_r [8*128];
  lcdc_state_t st_r, st_nxt;
  logic       don_r, don_nxt, segr_r, segr_nxt, comr_r, comr_nxt;
  logic       inv_r, inv_nxt, allon_r, allon_nxt, bias_r, bias_nxt;
  logic       rmw_r, rmw_nxt, ind_r, ind_nxt;
  logic [5:0] sl_r, sl_nxt, vol_r, vol_nxt;
  logic [3:0] pg_r, pg_nxt;
  logic [7:0] col_r, col_nxt, rdat_r, rdat_nxt;
  logic [2:0] pm_r, pm_nxt, rr_r, rr_nxt;
  logic [1:0] im_r, im_nxt, bst_r, bst_nxt;
  logic       ram_we;

  function automatic logic [9:0] ram_addr(input logic [3:0] p, input logic [7:0] c);
    return {p[2:0], c[6:0]};
  endfunction

  // Paired commands other than RMW and END differ only in bit 0, so one compare serves them.
  function automatic logic same_top7(input lcdc_byte_t a, input lcdc_byte_t b);
    return a[7:1] == b[7:1];
  endfunction

  always_comb begin
    st_nxt = st_r; don_nxt = don_r; segr_nxt = segr_r; comr_nxt = comr_r;
    inv_nxt = inv_r; allon_nxt = allon_r; bias_nxt = bias_r; rmw_nxt = rmw_r;
    ind_nxt = ind_r; sl_nxt = sl_r; vol_nxt = vol_r; pg_nxt = pg_r;
    col_nxt = col_r; pm_nxt = pm_r; rr_nxt = rr_r; im_nxt = im_r;
    bst_nxt = bst_r; rdat_nxt = rdat_r; ram_we = 1'b0;
    rc_nxt = (rc_r != '0) ? rc_r - RCW'(1) : rc_r;
    if (acc_v && !acc_wr && acc_dc) begin
      rdat_nxt = ram_r[ram_addr(pg_r, col_r)]; // R7
      if (!rmw_r) begin
        col_nxt = col_r + 8'h01; // R12 R27
      end
    end else if (acc_v && !acc_wr) begin
      rdat_nxt = {1'b0, !don_r, (rc_r != '0), 1'b0, 4'h0}; // R5
    end
    if (f_pop && f_dc) begin
      ram_we  = 1'b1; // R6
      col_nxt = col_r + 8'h01; // R12 R27
    end else if (f_pop) begin
      case (st_r)
        LCDC_ST_VOL: begin
          vol_nxt = f_d[5:0]; // R16
          st_nxt  = LCDC_ST_CMD;
        end
        LCDC_ST_IND: begin
          im_nxt = f_d[1:0]; // R17
          st_nxt = LCDC_ST_CMD;
        end
        LCDC_ST_BOOST: begin
          bst_nxt = f_d[1:0]; // R18
          st_nxt  = LCDC_ST_CMD;
        end
        default: begin
          if (same_top7(f_d, `LCDC_CMD_DISP)) don_nxt = f_d[0]; // R1
          else if (f_d[7:6] == `LCDC_TOP2_START) sl_nxt = f_d[5:0]; // R2
          else if (f_d[7:4] == `LCDC_NIB_PAGE) pg_nxt = f_d[3:0]; // R3
          else if (f_d[7:4] == `LCDC_NIB_COLHI) col_nxt = {f_d[3:0], col_r[3:0]}; // R4
          else if (f_d[7:4] == `LCDC_NIB_COLLO) col_nxt = {col_r[7:4], f_d[3:0]}; // R4
          else if (same_top7(f_d, `LCDC_CMD_SEG)) segr_nxt = f_d[0]; // R8
          else if (same_top7(f_d, `LCDC_CMD_INV)) inv_nxt = f_d[0]; // R9
          else if (same_top7(f_d, `LCDC_CMD_ALLON)) allon_nxt = f_d[0]; // R10
          else if (same_top7(f_d, `LCDC_CMD_BIAS)) bias_nxt = f_d[0]; // R11
          else if (f_d == `LCDC_CMD_RMW) rmw_nxt = 1'b1; // R12
          else if (f_d == `LCDC_CMD_END) rmw_nxt = 1'b0; // R12
          else if (f_d[7:4] == `LCDC_NIB_COM) comr_nxt = f_d[`LCDC_COM_BIT]; // R13
          else if (f_d[7:3] == `LCDC_TOP5_PWR) pm_nxt = f_d[2:0]; // R14
          else if (f_d[7:3] == `LCDC_TOP5_RATIO) rr_nxt = f_d[2:0]; // R15
          else if (f_d == `LCDC_CMD_VOL) st_nxt = LCDC_ST_VOL; // R16
          else if (same_top7(f_d, `LCDC_CMD_IND)) begin
            ind_nxt = f_d[0]; // R17
            st_nxt  = LCDC_ST_IND;
          end else if (f_d == `LCDC_CMD_BOOST) st_nxt = LCDC_ST_BOOST; // R18
          else if (f_d == `LCDC_CMD_SWRST) begin
            sl_nxt = '0; pg_nxt = '0; col_nxt = '0; rmw_nxt = 1'b0; // R28
            don_nxt = 1'b0; inv_nxt = 1'b0; allon_nxt = 1'b0; // R28
            segr_nxt = 1'b0; comr_nxt = 1'b0; // R28
          end
          // No-operation and the reserved test nibble, except the 0xf8 booster lead, fall through unchanged. R29 R20
        end
      endcase
    end
    if (!hw_reset_n_in) begin
      rc_nxt = RCW'(RST_CYC); // R21
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rc_r <= RCW'(RST_CYC);
    end else if (ce_in) begin
      rc_r <= rc_nxt;
    end
  end

  // Hardware reset pin loads the reset values of settings (contrast 0x20); RAM is left untouched on purpose.
  always_ff @(posedge clock_in) begin
    if (srst_in || (ce_in && !hw_reset_n_in)) begin
      st_r <= LCDC_ST_CMD; don_r <= 1'b0; segr_r <= 1'b0; comr_r <= 1'b0; // R21
      inv_r <= 1'b0; allon_r <= 1'b0; bias_r <= 1'b0; rmw_r <= 1'b0;
      ind_r <= 1'b0; sl_r <= '0; vol_r <= `LCDC_VOL_RST; pg_r <= '0;
      col_r <= '0; pm_r <= '0; rr_r <= `LCDC_RATIO_RST; im_r <= '0;
      bst_r <= '0; rdat_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt; don_r <= don_nxt; segr_r <= segr_nxt; comr_r <= comr_nxt;
      inv_r <= inv_nxt; allon_r <= allon_nxt; bias_r <= bias_nxt; rmw_r <= rmw_nxt;
      ind_r <= ind_nxt; sl_r <= sl_nxt; vol_r <= vol_nxt; pg_r <= pg_nxt;
      col_r <= col_nxt; pm_r <= pm_nxt; rr_r <= rr_nxt; im_r <= im_nxt;
      bst_r <= bst_nxt; rdat_r <= rdat_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (ce_in && ram_we) begin
      ram_r[ram_addr(pg_r, col_r)] <= f_d; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign bus_data_out       = rdat_r;
  assign bus_data_oe_out    = rd_q_r && parallel_sel_in; // R7
  assign display_on_out     = don_r; // R1
  assign start_line_out     = sl_r;
  assign page_out           = pg_r;
  assign column_out         = col_r;
  assign seg_reverse_out    = segr_r;
  assign com_reverse_out    = comr_r;
  assign invert_out         = inv_r;
  assign all_on_out         = allon_r;
  assign bias_1_7_out       = bias_r;
  assign power_mode_out     = pm_r;
  assign reg_ratio_out      = rr_r;
  assign contrast_out       = vol_r;
  assign indicator_on_out   = ind_r;
  assign indicator_mode_out = im_r;
  assign booster_out        = bst_r;
  assign power_saver_out    = !don_r && allon_r; // R19
  assign rmw_out            = rmw_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_disp;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && f_pop && !f_dc && st_r == LCDC_ST_CMD && f_d[7:1] == 7'h57)
      |=> (display_on_out == $past(f_d[0]));
  endproperty
  a_disp: assert property (p_disp) else $error("display on/off not applied"); // R1

  property p_page;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && f_pop && !f_dc && st_r == LCDC_ST_CMD && f_d[7:4] == 4'hb)
      |=> (page_out == $past(f_d[3:0]));
  endproperty
  a_page: assert property (p_page) else $error("page not loaded"); // R3

  property p_status;
    @(posedge clock_in) disable iff (srst_in)
      (ce_in && acc_v && !acc_wr && !acc_dc) |=> (bus_data_out[3:0] == 4'h0);
  endproperty
  a_status: assert property (p_status) else $error("status low nibble nonzero"); // R5

  property p_winc;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && f_pop && f_dc && !(acc_v && !acc_wr)) |=> (column_out == $past(col_r) + 8'h01);
  endproperty
  a_winc: assert property (p_winc) else $error("column not advanced"); // R27

  property p_rmw_read;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && rmw_r && acc_v && !acc_wr && acc_dc && !f_pop)
      |=> (column_out == $past(col_r));
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("read moved column in rmw"); // R12

  property p_saver;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && f_pop && !f_dc && st_r == LCDC_ST_CMD && f_d == `LCDC_CMD_DISP && allon_r)
      |=> power_saver_out;
  endproperty
  a_saver: assert property (p_saver) else $error("power saver mismatch"); // R19

  property p_vol;
    @(posedge clock_in) disable iff (srst_in || !hw_reset_n_in)
      (ce_in && f_pop && !f_dc && st_r == LCDC_ST_VOL) |=> (contrast_out == $past(f_d[5:0]));
  endproperty
  a_vol: assert property (p_vol) else $error("contrast byte not stored"); // R16

  property p_reset;
    @(posedge clock_in) disable iff (srst_in)
      (ce_in && !hw_reset_n_in) |=> (!display_on_out && page_out == 4'h0 && busy_out);
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear"); // R21

  property p_serial_oe;
    @(posedge clock_in) disable iff (srst_in)
      !parallel_sel_in |-> !bus_data_oe_out;
  endproperty
  a_serial_oe: assert property (p_serial_oe) else $error("drive in serial mode"); // R26
endmodule // lcdc_decoder

/* File: dv/lcdc_host_model.sv */
/*
  Host processor model that drives the decoder pins in 8080, 6800 or serial style.
  Assumes the bench resolves the shared data bus from the decoder's output enable.
*/
`timescale 1ns/1ps
module lcdc_host_model (
  input  wire logic       clock_in,
  output logic            hw_reset_n_out,
  output logic            parallel_sel_out,
  output logic            bus_style_select_out,
  output logic            unit_select_n_out,
  output logic            data_cmd_out,
  output logic            rd_e_out,
  output logic            wr_rw_out,
  output logic [7:0]      data_out
);
  logic [7:0] last_r;
  initial begin
    hw_reset_n_out = 1'b1;
    parallel_sel_out = 1'b1;
    bus_style_select_out = 1'b0;
    unit_select_n_out = 1'b1;
    data_cmd_out = 1'b0;
    rd_e_out = 1'b1;
    wr_rw_out = 1'b1;
    data_out = 8'h00;
    last_r = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Chip select drops and strobes go idle for the new style on the same edge, so a style change never fakes an access.
  task automatic mode(input logic par, input logic sty);
    @(posedge clock_in);
    unit_select_n_out <= 1'b1;
    parallel_sel_out <= par;
    bus_style_select_out <= sty;
    rd_e_out <= ~sty;
    wr_rw_out <= 1'b1;
    cyc(2);
  endtask
  task automatic sel(input logic dc, input logic [7:0] b);
    unit_select_n_out <= 1'b0;
    data_cmd_out <= dc;
    data_out <= b;
    last_r <= b;
  endtask
  // A released bus shows the inverse of the last byte, never a stale copy.
  task automatic drop();
    unit_select_n_out <= 1'b1;
    data_out <= ~last_r;
    cyc(1);
  endtask
  // Test codes with upper nibble 1111 are never issued; 0xf8 only leads a pair.
  task automatic wr80(input logic dc, input logic [7:0] b);
    @(posedge clock_in);
    sel(dc, b);
    wr_rw_out <= 1'b0;
    cyc(2);
    wr_rw_out <= 1'b1;
    cyc(2);
    drop();
  endtask
  task automatic rd80(input logic dc);
    @(posedge clock_in);
    sel(dc, ~last_r);
    rd_e_out <= 1'b0;
    cyc(4);
    rd_e_out <= 1'b1;
    cyc(2);
    drop();
  endtask
  task automatic wr68(input logic dc, input logic [7:0] b);
    @(posedge clock_in);
    sel(dc, b);
    wr_rw_out <= 1'b0;
    cyc(1);
    rd_e_out <= 1'b1;
    cyc(2);
    rd_e_out <= 1'b0;
    cyc(2);
    wr_rw_out <= 1'b1;
    drop();
  endtask
  // Serial clock stands low between frames; unused lines stay high.
  task automatic wrser(input logic dc, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock_in);
      unit_select_n_out <= 1'b0;
      data_cmd_out <= dc;
      data_out <= {b[i], 1'b0, 6'h3f};
      cyc(2);
      data_out <= {b[i], 1'b1, 6'h3f};
      cyc(1);
    end
    cyc(2);
    unit_select_n_out <= 1'b1;
    data_out <= {~b[0], 1'b0, 6'h3f};
    cyc(1);
  endtask
  task automatic pulse_reset(input int n);
    @(posedge clock_in);
    hw_reset_n_out <= 1'b0;
    cyc(n);
    hw_reset_n_out <= 1'b1;
  endtask
endmodule // lcdc_host_model

/* File: dv/tb_top.sv */
/*
  Self-checking bench for the display command decoder.
  Assumes lcdc_pkg is compiled first and the host model drives every bus pin.
*/
`timescale 1ns/1ps
module tb_top;
  import lcdc_pkg::*;
  logic        clock_in = 1'b0;
  logic        srst_in;
  logic        ce_in;
  logic        hw_rst_n, par_sel, style, cs_n, dc, rd_e, wr_rw, oe, oe_q = 1'b0;
  logic [7:0]  host_data, bus_wire, pg, col;
  logic [7:0]  d [3];
  lcdc_byte_t  rd_data;
  logic        disp, seg_rev, com_rev, inv, all_on, bias17, ind_on, saver, rmw, busy;
  logic [5:0]  start, contrast;
  logic [3:0]  page;
  logic [7:0]  column;
  logic [2:0]  pwr, ratio;
  logic [1:0]  ind_mode, boost;
  logic [15:0] exp_q [$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0;
  int          seed, n;
  always #4 clock_in = ~clock_in;
  // Bus wire: the decoder wins while it drives, the host otherwise.
  assign bus_wire = oe ? rd_data : host_data;
  lcdc_host_model HOST (.clock_in(clock_in), .hw_reset_n_out(hw_rst_n),
    .parallel_sel_out(par_sel), .bus_style_select_out(style), .unit_select_n_out(cs_n),
    .data_cmd_out(dc), .rd_e_out(rd_e), .wr_rw_out(wr_rw), .data_out(host_data));
  lcdc_decoder DUT (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in),
    .hw_reset_n_in(hw_rst_n), .parallel_sel_in(par_sel), .bus_style_select_in(style),
    .unit_select_n_in(cs_n), .data_cmd_in(dc), .rd_e_in(rd_e), .wr_rw_in(wr_rw),
    .bus_data_in(bus_wire), .bus_data_out(rd_data), .bus_data_oe_out(oe),
    .display_on_out(disp), .start_line_out(start), .page_out(page), .column_out(column),
    .seg_reverse_out(seg_rev), .com_reverse_out(com_rev), .invert_out(inv),
    .all_on_out(all_on), .bias_1_7_out(bias17), .power_mode_out(pwr),
    .reg_ratio_out(ratio), .contrast_out(contrast), .indicator_on_out(ind_on),
    .indicator_mode_out(ind_mode), .booster_out(boost), .power_saver_out(saver),
    .rmw_out(rmw), .busy_out(busy));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge clock_in);
  endtask
  task automatic cmd(input logic [7:0] b);
    HOST.wr80(1'b0, b);
    settle();
  endtask
  task automatic set_col(input logic [7:0] c);
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask
  task automatic wait_idle();
    n = 0;
    @(negedge clock_in);
    while (busy === 1'b1 && n < 400) begin
      @(negedge clock_in);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Each read result is paired with the oldest note; the mask hides undefined flags.
  always @(posedge clock_in) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q === 1'b0) begin
      if (exp_q.size() == 0) chk("read_extra", 8'h00, 8'hff);
      else begin
        chk("read_data", rd_data & exp_q[0][15:8], exp_q[0][7:0]);
        void'(exp_q.pop_front());
      end
    end
  end
  // The run needs about a thousand cycles; the ceiling leaves ample room.
  always @(posedge clock_in) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    seed = 5012;
    repeat (6) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    chk("busy_after_reset", 8'(busy), 8'h01);
    chk("contrast_reset", 8'(contrast), 8'h20);
    wait_idle();
    chk("reset_time", 8'(n <= 130), 8'h01);
    $display("test reset done");
    pg = $random(seed) & 8'h07;
    col = $random(seed) & 8'h77;
    cmd(8'he2);
    cmd(8'ha3);
    chk("bias", 8'(bias17), 8'h01);
    cmd(8'ha1);
    chk("seg_rev", 8'(seg_rev), 8'h01);
    cmd(8'hc7);
    chk("com_rev_low_bits", 8'(com_rev), 8'h00);
    cmd(8'hc8);
    chk("com_rev", 8'(com_rev), 8'h01);
    cmd(8'h25);
    chk("reg_ratio", 8'(ratio), 8'h05);
    cmd(8'h2e);
    chk("power_mode", 8'(pwr), 8'h06);
    cmd(8'h81);
    cmd(8'h13);
    chk("contrast", 8'(contrast), 8'h13);
    cmd(8'h6a);
    chk("start_line", 8'(start), 8'h2a);
    cmd({4'hb, pg[3:0]});
    chk("page", 8'(page), pg);
    set_col(col);
    chk("column", column, col);
    cmd(8'haf);
    chk("display_on", 8'(disp), 8'h01);
    cmd(8'ha7);
    chk("invert", 8'(inv), 8'h01);
    cmd(8'had);
    cmd(8'h02);
    chk("indicator", {5'h0, ind_on, ind_mode}, 8'h06);
    cmd(8'hf8);
    cmd(8'h01);
    chk("booster", 8'(boost), 8'h01);
    cmd(8'ha5);
    chk("all_on", {6'h0, all_on, saver}, 8'h02);
    exp_q.push_back({8'h4f, 8'h00});
    HOST.rd80(1'b0);
    cmd(8'hae);
    chk("power_saver", 8'(saver), 8'h01);
    exp_q.push_back({8'h4f, 8'h40});
    HOST.rd80(1'b0);
    cmd(8'ha4);
    chk("all_off_saver", {6'h0, all_on, saver}, 8'h00);
    $display("test commands done");
    for (int i = 0; i < 3; i++) begin
      d[i] = $random(seed);
      HOST.wr80(1'b1, d[i]);
    end
    settle();
    chk("col_after_writes", column, col + 8'h03);
    set_col(col);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back({8'hff, d[i]});
      HOST.rd80(1'b1);
    end
    settle();
    chk("col_after_reads", column, col + 8'h03);
    $display("test data done");
    set_col(col);
    cmd(8'he0);
    chk("rmw_on", 8'(rmw), 8'h01);
    exp_q.push_back({8'hff, d[0]});
    HOST.rd80(1'b1);
    settle();
    chk("rmw_read_col", column, col);
    d[0] = ~d[0];
    HOST.wr80(1'b1, d[0]);
    settle();
    chk("rmw_write_col", column, col + 8'h01);
    cmd(8'hee);
    chk("rmw_off", 8'(rmw), 8'h00);
    $display("test rmw done");
    HOST.mode(1'b1, 1'b1);
    HOST.wr68(1'b0, 8'hb3);
    settle();
    chk("page_6800", 8'(page), 8'h03);
    HOST.mode(1'b0, 1'b0);
    HOST.wrser(1'b0, 8'h5a);
    settle();
    chk("start_serial", 8'(start), 8'h1a);
    HOST.mode(1'b1, 1'b0);
    $display("test bus styles done");
    cmd(8'he3);
    chk("nop_page", 8'(page), 8'h03);
    chk("nop_start", 8'(start), 8'h1a);
    cmd(8'he2);
    chk("swrst_ptrs", {page, column[3:0]}, 8'h00);
    chk("swrst_set", {4'h0, disp, inv, seg_rev, com_rev}, 8'h00);
    chk("swrst_contrast", 8'(contrast), 8'h13);
    cmd({4'hb, pg[3:0]});
    set_col(col);
    exp_q.push_back({8'hff, d[0]});
    HOST.rd80(1'b1);
    $display("test soft reset done");
    cmd(8'haf);
    // A reset pulse while the clock enable is low must leave all state frozen.
    @(posedge clock_in);
    ce_in <= 1'b0;
    HOST.pulse_reset(4);
    @(posedge clock_in);
    ce_in <= 1'b1;
    settle();
    chk("ce_freeze", {6'h0, disp, busy}, 8'h02);
    HOST.pulse_reset(125);
    repeat (2) @(negedge clock_in);
    chk("hw_reset_disp", 8'(disp), 8'h00);
    chk("hw_reset_busy", 8'(busy), 8'h01);
    for (int i = 1; i < 10; i++) HOST.wr80(1'b0, 8'hb0 + 8'(i));
    wait_idle();
    repeat (3) settle();
    chk("fifo_page", 8'(page), 8'h08);
    $display("test reset pin and buffer done");
    repeat (20) @(negedge clock_in);
    chk("reads_pending", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule // tb_top
